// ---- verilog/tsc_cfg.svh ----
// Purpose: Offsets, field positions, reset values and code bytes of the tx codec.
// Assumes: Included by the package and the top module.
// Notes: Definitions only.
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH
// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define TSC_OFS_CTRL 4'h0
`define TSC_OFS_PPM 4'h4
`define TSC_OFS_STAT 4'h8
`define TSC_CTRL_RST 32'h0000_0000
`define TSC_PPM_RST 10'h064
// CTRL fields
`define TSC_F_MODE 1:0
`define TSC_F_DESW 3:2
`define TSC_F_INSEL 6:4
`define TSC_F_OUTSRC 7
`define TSC_F_OUTLINE 10:8
// ----------------------------------------------------------------
// Code-group bytes
// ----------------------------------------------------------------
`define TSC_K28_0 8'h1C
`define TSC_K28_1 8'h3C
`define TSC_K28_2 8'h5C
`define TSC_K28_3 8'h7C
`define TSC_K28_4 8'h9C
`define TSC_K28_5 8'hBC
`define TSC_K28_6 8'hDC
`define TSC_K23_7 8'hF7
`define TSC_K27_7 8'hFB
`define TSC_K29_7 8'hFD
`define TSC_K30_7 8'hFE
`define TSC_X_IDLE 8'h07
`define TSC_D5_6 8'hC5
`define TSC_D16_2 8'h50
`define TSC_D21_5 8'hB5
`define TSC_D2_2 8'h42
// ----------------------------------------------------------------
// Idle spacing and lines
// ----------------------------------------------------------------
`define TSC_A_MIN 5'd16
`define TSC_A_SPAN_BITS 4
`define TSC_PRBS_SEED 7'h7F
`define TSC_N_SHARED 5
`endif

// ---- verilog/tsc_pkg.sv ----
// Purpose: Types of the transceiver tx codec.
// Assumes: tsc_cfg.svh holds the numbers.
// Notes: The whole state of the top is one packed struct.
`include "tsc_cfg.svh"
package tsc_pkg;
    typedef enum logic [1:0] {TSC_BYPASS, TSC_PCIE, TSC_XAUI, TSC_GIGABIT_ETHERNET_MODE} tsc_mode_e;
    typedef enum logic [1:0] {TSC_W8, TSC_W10, TSC_W16, TSC_W20} tsc_width_e;
    typedef enum logic {TSC_TRACK_REF, TSC_TRACK_DATA} tsc_cru_e;
    typedef struct packed {
        logic wr_pend;
        logic [3:0] wr_addr;
        logic [31:0] rdata;
        tsc_mode_e mode;
        tsc_width_e des_w;
        logic [2:0] in_sel;
        logic out_src;
        logic [2:0] out_line;
        logic [9:0] ppm_thr;
        tsc_cru_e cru;
        logic [7:0] code;
        logic k;
        logic rd;
        logic prev_comma;
        logic prev_term;
        logic [6:0] prbs;
        logic [4:0] a_cnt;
        logic [19:0] shreg;
        logic [4:0] bit_cnt;
        logic [19:0] word;
        logic word_vld;
    } tsc_state_s;
endpackage

// ---- verilog/tsc_top.sv ----
// Purpose: Protocol tx state machine, clock-recovery lock select, deserializer
//          and reference-clock routing of one transceiver channel.
// Assumes: Fabric inputs are on ref_clk; AHB-Lite slave with zero wait states.
// Notes: Operation
// Operation
// - Three protocol modes or bypass.
// - GbE idle sets rewritten to first/second idle.
// - First idle is K28.5 then D5.6.
// - Second idle is K28.5+ then D16.2.
// - Configuration sets are never produced or altered.
// - Idle choice leaves running disparity negative.
// - XAUI data byte sent as data group.
// - Idle byte gives R/A/K, K after terminate.
// - Sequence, start, terminate, error bytes mapped.
// - Other control bytes become error K30.7.
// - Reserved control bytes kept as reserved groups.
// - R or K picked by x^7+x^6+1 PRBS.
// - Alignment idle after 16 to 31 idles; one due right after terminate is sent as K and the count reloads.
// - Recovery tracks reference or data, status out.
// - Auto moves to data only within ppm threshold.
// - Force-data wins, force-ref next, else auto.
// - Unconnected overrides mean automatic mode.
// - Deserializer word width 8, 10, 16, 20.
// - First serial bit is word LSB.
// - Incoming reference from five lines or global pin.
// - Two local references, at most one outgoing line driven.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_cfg.svh"
module tsc_top
    import tsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Parallel transmit side from the MAC or PCS
    input wire logic [7:0] tx_data_in,
    input wire logic tx_ctrl_in,
    output logic [7:0] tx_code_out,
    output logic tx_k_out,
    output logic tx_rd_out,
    // Clock recovery
    input wire logic rx_lock_to_data = 1'b0,
    input wire logic rx_lock_to_ref = 1'b0,
    input wire logic [9:0] cru_ppm_err,
    output logic rx_freq_locked,
    // Deserializer
    input wire logic rx_bit,
    input wire logic rx_bit_stb,
    output logic [19:0] rx_word,
    output logic rx_word_vld,
    // Reference clock routing
    input wire logic local_ref_clock_a,
    input wire logic local_ref_clock_b,
    input wire logic [4:0] shared_ref_clock_lines,
    input wire logic global_clk_pin,
    output logic incoming_ref_clk,
    output logic outgoing_ref_clk,
    output logic [4:0] shared_line_drive_en
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // A 6b sub-block that is unbalanced flips running disparity.
    function automatic logic unb6(input logic [4:0] x, input logic k);
        unique case (x)
            5'd0, 5'd1, 5'd2, 5'd4, 5'd8, 5'd15, 5'd16, 5'd23,
            5'd24, 5'd27, 5'd29, 5'd30, 5'd31: unb6 = 1'b1;
            5'd28: unb6 = k;
            default: unb6 = 1'b0;
        endcase
    endfunction

    function automatic logic unb4(input logic [2:0] y);
        unb4 = (y == 3'd0) || (y == 3'd4) || (y == 3'd7);
    endfunction

    function automatic logic next_rd(input logic rd, input logic [7:0] b, input logic k);
        next_rd = rd ^ unb6(b[4:0], k) ^ unb4(b[7:5]);
    endfunction

    function automatic logic [19:0] reg_view(input tsc_state_s s, input logic [3:0] a);
        reg_view = 20'h0_0000;
        unique case (a)
            `TSC_OFS_CTRL: reg_view = {9'h000, s.out_line, s.out_src, s.in_sel,
                                      s.des_w, s.mode};
            `TSC_OFS_PPM: reg_view = {10'h000, s.ppm_thr};
            `TSC_OFS_STAT: reg_view = {17'h0_0000, s.rd, s.prbs[0], s.cru};
            default: reg_view = 20'h0_0000;
        endcase
    endfunction

    tsc_state_s cur_q;
    tsc_state_s nxt_d;

    logic addr_take;
    logic [2:0] lock_mode;
    logic [7:0] sym;
    logic sym_k;
    logic [5:0] need_bits;

    assign addr_take = hsel && htrans[1] && hready;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_d = cur_q;
        sym = tx_data_in;
        sym_k = tx_ctrl_in;
        lock_mode = {rx_lock_to_data, rx_lock_to_ref, 1'b0};
        need_bits = 6'd8;

        // Bus writes land at the end of the data phase.
        nxt_d.wr_pend = addr_take && hwrite;
        nxt_d.wr_addr = {haddr[3:2], 2'b00};
        if (cur_q.wr_pend) begin
            unique case (cur_q.wr_addr)
                `TSC_OFS_CTRL: begin
                    nxt_d.mode = tsc_mode_e'(hwdata[`TSC_F_MODE]);
                    nxt_d.des_w = tsc_width_e'(hwdata[`TSC_F_DESW]);
                    nxt_d.in_sel = hwdata[`TSC_F_INSEL];
                    nxt_d.out_src = hwdata[`TSC_F_OUTSRC];
                    nxt_d.out_line = hwdata[`TSC_F_OUTLINE];
                end
                `TSC_OFS_PPM: nxt_d.ppm_thr = hwdata[9:0];
                default: nxt_d.wr_addr = cur_q.wr_addr;
            endcase
        end
        // Reading from the updated copy makes write-then-read return new data.
        if (addr_take && !hwrite) begin
            nxt_d.rdata = {12'h000, reg_view(nxt_d, {haddr[3:2], 2'b00})};
        end

        // ------------------------------------------------------------
        // Transmit symbol mapping per protocol
        // ------------------------------------------------------------
        nxt_d.prev_comma = 1'b0;
        nxt_d.prev_term = 1'b0;
        unique case (cur_q.mode)
            TSC_GIGABIT_ETHERNET_MODE: begin
                if (cur_q.prev_comma && !tx_ctrl_in && tx_data_in != `TSC_D21_5
                        && tx_data_in != `TSC_D2_2) begin
                    // Disparity after the comma decides which idle follows.
                    sym = cur_q.rd ? `TSC_D16_2 : `TSC_D5_6;
                end
                nxt_d.prev_comma = tx_ctrl_in && (tx_data_in == `TSC_K28_5);
            end
            TSC_XAUI: begin
                if (tx_ctrl_in) begin
                    unique case (tx_data_in)
                        `TSC_X_IDLE: begin
                            nxt_d.prbs = {cur_q.prbs[5:0],
                                          cur_q.prbs[6] ^ cur_q.prbs[5]};
                            if (cur_q.prev_term) begin
                                sym = `TSC_K28_5;
                            end else if (cur_q.a_cnt == 5'd0) begin
                                sym = `TSC_K28_3;
                            end else begin
                                sym = cur_q.prbs[6] ? `TSC_K28_5 : `TSC_K28_0;
                            end
                            if (cur_q.a_cnt == 5'd0) begin
                                // Reload with 16 plus a four-bit random offset.
                                nxt_d.a_cnt = `TSC_A_MIN +
                                    {1'b0, cur_q.prbs[`TSC_A_SPAN_BITS-1:0]};
                            end else begin
                                nxt_d.a_cnt = cur_q.a_cnt - 5'd1;
                            end
                        end
                        `TSC_K28_4, `TSC_K27_7, `TSC_K29_7,
                        `TSC_K30_7: sym = tx_data_in;
                        `TSC_K28_0, `TSC_K28_1, `TSC_K28_2, `TSC_K28_3,
                        `TSC_K28_5, `TSC_K28_6, `TSC_K23_7: sym = tx_data_in;
                        default: sym = `TSC_K30_7;
                    endcase
                    nxt_d.prev_term = (tx_data_in == `TSC_K29_7);
                end else begin
                    sym = tx_data_in;
                end
            end
            TSC_PCIE: sym = tx_data_in;
            TSC_BYPASS: begin
                // No protocol handling; the symbol goes straight through.
                sym = tx_data_in;
            end
        endcase
        nxt_d.code = sym;
        nxt_d.k = sym_k;
        nxt_d.rd = next_rd(cur_q.rd, sym, sym_k);

        // ------------------------------------------------------------
        // Clock recovery lock mode
        // ------------------------------------------------------------
        // An open override port takes its default of zero, which is automatic.
        if (rx_lock_to_data) begin
            nxt_d.cru = TSC_TRACK_DATA;
        end else if (rx_lock_to_ref) begin
            nxt_d.cru = TSC_TRACK_REF;
        end else if (cru_ppm_err <= cur_q.ppm_thr) begin
            nxt_d.cru = TSC_TRACK_DATA;
        end else begin
            // Drifting out of range falls back to the reference.
            nxt_d.cru = TSC_TRACK_REF;
        end

        // ------------------------------------------------------------
        // Deserializer
        // ------------------------------------------------------------
        unique case (cur_q.des_w)
            TSC_W8: need_bits = 6'd8;
            TSC_W10: need_bits = 6'd10;
            TSC_W16: need_bits = 6'd16;
            TSC_W20: need_bits = 6'd20;
        endcase
        nxt_d.word_vld = 1'b0;
        if (rx_bit_stb) begin
            // Shifting in from the top leaves the first bit lowest.
            nxt_d.shreg = {rx_bit, cur_q.shreg[19:1]};
            if ({1'b0, cur_q.bit_cnt} == need_bits - 6'd1) begin
                nxt_d.bit_cnt = 5'd0;
                nxt_d.word_vld = 1'b1;
                nxt_d.word = nxt_d.shreg >> (6'd20 - need_bits);
            end else begin
                nxt_d.bit_cnt = cur_q.bit_cnt + 5'd1;
            end
        end
        // A width change restarts word assembly.
        if (nxt_d.des_w != cur_q.des_w) begin
            nxt_d.bit_cnt = 5'd0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur_q <= '0;
            cur_q.ppm_thr <= `TSC_PPM_RST;
            cur_q.prbs <= `TSC_PRBS_SEED;
            cur_q.a_cnt <= `TSC_A_MIN;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ----------------------------------------------------------------
    // Reference clock routing
    // ----------------------------------------------------------------
    // Static selects only; changing them live may glitch the clock.
    always_comb begin
        if (cur_q.in_sel < 3'(`TSC_N_SHARED)) begin
            incoming_ref_clk = shared_ref_clock_lines[cur_q.in_sel];
        end else begin
            incoming_ref_clk = global_clk_pin;
        end
        outgoing_ref_clk = cur_q.out_src ? local_ref_clock_b : local_ref_clock_a;
        shared_line_drive_en = 5'b0_0000;
        if (cur_q.out_line < 3'(`TSC_N_SHARED)) begin
            shared_line_drive_en[cur_q.out_line] = 1'b1;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = cur_q.rdata;
    assign tx_code_out = cur_q.code;
    assign tx_k_out = cur_q.k;
    assign tx_rd_out = cur_q.rd;
    assign rx_freq_locked = (cur_q.cru == TSC_TRACK_DATA);
    assign rx_word = cur_q.word;
    assign rx_word_vld = cur_q.word_vld;
endmodule // tsc_top
`default_nettype wire

// ---- dv/tsc_top_chk.sv ----
// Purpose: Port assertions for tsc_top.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound into every tsc_top instance.
`timescale 1ns/1ps
`default_nettype none
module tsc_top_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic tx_ctrl_in,
    input wire logic [7:0] tx_code_out,
    input wire logic tx_k_out,
    input wire logic tx_rd_out,
    input wire logic rx_lock_to_data,
    input wire logic rx_lock_to_ref,
    input wire logic rx_freq_locked,
    input wire logic rx_bit_stb,
    input wire logic rx_word_vld,
    input wire logic [4:0] shared_line_drive_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    property p_force_data; rx_lock_to_data |=> rx_freq_locked; endproperty
    a_force_data: assert property (p_force_data) else $error("data lock not forced");
    property p_force_ref; rx_lock_to_ref && !rx_lock_to_data |=> !rx_freq_locked; endproperty
    a_force_ref: assert property (p_force_ref) else $error("ref lock not forced");
    property p_rise_cause;
        $rose(rx_freq_locked) |-> $past(rx_lock_to_data) || !$past(rx_lock_to_ref);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("data lock while ref forced");
    // A word pulse must close a strobe and cannot be held.
    property p_vld_pulse; rx_word_vld |=> !rx_word_vld; endproperty
    a_vld_pulse: assert property (p_vld_pulse) else $error("word valid held");
    property p_vld_cause; rx_word_vld |-> $past(rx_bit_stb); endproperty
    a_vld_cause: assert property (p_vld_cause) else $error("word without strobe");
    property p_drive_one; $onehot0(shared_line_drive_en); endproperty
    a_drive_one: assert property (p_drive_one) else $error("several lines driven");
    property p_idle_neg;
        !tx_k_out && (tx_code_out == 8'hC5 || tx_code_out == 8'h50)
            && $past(tx_k_out && tx_code_out == 8'hBC) |-> !tx_rd_out;
    endproperty
    a_idle_neg: assert property (p_idle_neg) else $error("idle set ends positive");
    property p_k_follow; !$past(rst) |-> tx_k_out == $past(tx_ctrl_in); endproperty
    a_k_follow: assert property (p_k_follow) else $error("control flag lost");
    property p_rdata_hold;
        !$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule // tsc_top_chk
bind tsc_top tsc_top_chk chk_u (.ref_clk, .rst, .hsel, .htrans, .hready, .hwrite, .hrdata,
    .tx_ctrl_in, .tx_code_out, .tx_k_out, .tx_rd_out, .rx_lock_to_data, .rx_lock_to_ref,
    .rx_freq_locked, .rx_bit_stb, .rx_word_vld, .shared_line_drive_en);
`default_nettype wire

// ---- dv/tsc_fab_model.sv ----
// Purpose: Fabric MAC side that streams byte and control pairs.
// Assumes: Symbols are queued off the rising edge.
// Notes: An empty queue sends control idle, as a real MAC would between frames.
`timescale 1ns/1ps
`default_nettype none
module tsc_fab_model (
    input wire logic ref_clk,
    output logic [7:0] tx_data,
    output logic tx_ctrl
);
    logic [8:0] q[$];
    initial begin
        {tx_ctrl, tx_data} = 9'h107;
    end
    always @(posedge ref_clk) begin
        if (q.size() > 0) {tx_ctrl, tx_data} <= q.pop_front();
        else {tx_ctrl, tx_data} <= 9'h107;
    end
    task push(input logic [8:0] v);
        q.push_back(v);
    endtask
endmodule // tsc_fab_model
`default_nettype wire

// ---- dv/test_transceiver_tx_state_machine_cru_lock.sv ----
// Purpose: Self-checking bench for tsc_top.
// Assumes: Zero-wait AHB-Lite slave; transmit output one cycle after input.
// Notes: Stream expectations of 9'h1FF are skipped, since start disparity is unknown.
`timescale 1ns/1ps
`default_nettype none
module test_transceiver_tx_state_machine_cru_lock;
    logic ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp, tx_ctrl_in, tx_k_out, tx_rd_out;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] tx_data_in, tx_code_out;
    logic rx_lock_to_data, rx_lock_to_ref, rx_freq_locked, rx_bit, rx_bit_stb, rx_word_vld;
    logic [9:0] cru_ppm_err;
    logic [19:0] rx_word;
    logic local_ref_clock_a, local_ref_clock_b, global_clk_pin, incoming_ref_clk, outgoing_ref_clk;
    logic [4:0] shared_ref_clock_lines, shared_line_drive_en;
    int error_cnt, check_count;
    logic [8:0] sin[$], sexp[$];
    assign hready = hreadyout;
    tsc_top dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .tx_data_in, .tx_ctrl_in, .tx_code_out, .tx_k_out,
        .tx_rd_out, .rx_lock_to_data, .rx_lock_to_ref, .cru_ppm_err, .rx_freq_locked, .rx_bit,
        .rx_bit_stb, .rx_word, .rx_word_vld, .local_ref_clock_a, .local_ref_clock_b,
        .shared_ref_clock_lines, .global_clk_pin, .incoming_ref_clk, .outgoing_ref_clk,
        .shared_line_drive_en);
    tsc_fab_model fab_u (.ref_clk, .tx_data(tx_data_in), .tx_ctrl(tx_ctrl_in));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        // Start on a rising edge so the address phase never moves mid-cycle.
        @(posedge ref_clk);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask
    // Pushing at the falling edge keeps the model's pop free of a race.
    task run_s;
        @(negedge ref_clk);
        foreach (sin[i]) fab_u.push(sin[i]);
        repeat (2) @(posedge ref_clk);
        foreach (sexp[i]) begin
            @(negedge ref_clk);
            if (sexp[i] !== 9'h1FF) chk("tx", {tx_k_out, tx_code_out}, sexp[i]);
        end
    endtask
    task cru(input logic d, input logic r, input logic [9:0] e, input logic x);
        rx_lock_to_data <= d;
        rx_lock_to_ref <= r;
        cru_ppm_err <= e;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("locked", rx_freq_locked, x);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs;
        bus(0, 32'h0, 32'h0);
        chk("ctrl_rst", rdv, 32'h0);
        bus(0, 32'h4, 32'h0);
        chk("ppm_rst", rdv, 32'h64);
        bus(1, 32'h4, 32'h20);
        bus(0, 32'h4, 32'h0);
        chk("ppm", rdv, 32'h20);
        bus(1, 32'hC, 32'hFFFF);
        bus(0, 32'hC, 32'h0);
        chk("unmapped", rdv, 32'h0);
        for (int m = 0; m < 2; m++) begin
            bus(1, 32'h0, m);
            sin = '{9'h155};
            sexp = '{9'h155};
            run_s();
        end
    endtask
    task t_cru;
        cru(0, 0, 10'h30, 0);
        cru(0, 0, 10'h20, 1);
        cru(0, 0, 10'h21, 0);
        cru(0, 1, 10'h10, 0);
        cru(1, 1, 10'h30, 1);
        cru(1, 0, 10'h30, 1);
        bus(0, 32'h8, 32'h0);
        chk("stat", rdv[0], 1'b1);
        cru(0, 0, 10'h3FF, 0);
    endtask
    task t_xaui;
        int last;
        logic [7:0] c;
        logic sr, sk;
        bus(1, 32'h0, 32'h2);
        sin = '{9'h000, 9'h0FF, 9'h19C, 9'h1FB, 9'h1FE, 9'h155, 9'h13C, 9'h1F7, 9'h1FD, 9'h107};
        sexp = '{9'h000, 9'h0FF, 9'h19C, 9'h1FB, 9'h1FE, 9'h1FE, 9'h13C, 9'h1F7, 9'h1FD, 9'h1BC};
        run_s();
        last = -1;
        sr = 1'b0;
        sk = 1'b0;
        for (int i = 0; i < 120; i++) begin
            @(negedge ref_clk);
            c = tx_code_out;
            chk("idle", c == 8'h1C || c == 8'h7C || c == 8'hBC, 1'b1);
            sr |= c == 8'h1C;
            sk |= c == 8'hBC;
            if (c == 8'h7C) begin
                if (last >= 0) chk("a_gap", i - last > 16 && i - last < 33, 1'b1);
                last = i;
            end
        end
        chk("r_and_k", sr && sk, 1'b1);
    endtask
    task t_gigabit_ethernet_mode;
        bus(1, 32'h0, 32'h3);
        sin = '{9'h1BC, 9'h04A, 9'h1BC, 9'h04A, 9'h1BC, 9'h0B5, 9'h1BC, 9'h04A, 9'h1BC, 9'h042};
        sexp = '{9'h1BC, 9'h1FF, 9'h1BC, 9'h050, 9'h1BC, 9'h0B5, 9'h1BC, 9'h0C5, 9'h1BC, 9'h042};
        run_s();
    endtask
    task t_des;
        int w[4];
        logic [19:0] p, m;
        int n;
        w = '{8, 10, 16, 20};
        p = 20'hA_5C3B;
        for (int i = 0; i < 4; i++) begin
            bus(1, 32'h0, i << 2);
            m = 20'hF_FFFF >> (20 - w[i]);
            for (int b = 0; b < w[i]; b++) begin
                rx_bit <= p[b];
                rx_bit_stb <= 1'b1;
                @(posedge ref_clk);
            end
            rx_bit_stb <= 1'b0;
            n = 0;
            do begin
                @(negedge ref_clk);
                n++;
            end while (rx_word_vld !== 1'b1 && n < 3);
            chk("vld", rx_word_vld, 1'b1);
            chk("word", rx_word & m, p & m);
        end
    endtask
    task t_clk;
        bus(1, 32'h0, 32'h3A0);
        shared_ref_clock_lines <= 5'b00100;
        local_ref_clock_b <= 1'b1;
        @(negedge ref_clk);
        chk("drive", shared_line_drive_en, 5'b01000);
        chk("in_hi", incoming_ref_clk, 1'b1);
        chk("out_hi", outgoing_ref_clk, 1'b1);
        shared_ref_clock_lines <= 5'b11011;
        local_ref_clock_b <= 1'b0;
        @(negedge ref_clk);
        chk("in_lo", incoming_ref_clk, 1'b0);
        chk("out_lo", outgoing_ref_clk, 1'b0);
        bus(1, 32'h0, 32'h550);
        global_clk_pin <= 1'b1;
        @(negedge ref_clk);
        chk("in_glob", incoming_ref_clk, 1'b1);
        chk("drive_none", shared_line_drive_en, 5'b00000);
        chk("out_a_lo", outgoing_ref_clk, 1'b0);
        local_ref_clock_a <= 1'b1;
        @(negedge ref_clk);
        chk("out_a_hi", outgoing_ref_clk, 1'b1);
    endtask
    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        hsize = 3'h2;
        {htrans, haddr, hwdata, cru_ppm_err, shared_ref_clock_lines} = '0;
        {hwrite, rx_lock_to_data, rx_lock_to_ref, rx_bit, rx_bit_stb} = '0;
        {local_ref_clock_a, local_ref_clock_b, global_clk_pin} = '0;
        error_cnt = 0;
        check_count = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs;
        t_cru;
        t_xaui;
        t_gigabit_ethernet_mode;
        t_des;
        t_clk;
        tally_and_finish;
    end
    // The tests need about three hundred cycles; twenty thousand means a hang.
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish;
    end
endmodule // test_transceiver_tx_state_machine_cru_lock
`default_nettype wire
